// file: hw/base_clock_defs.svh
// Constants of the serial base-clock selector: offsets, fields, resets.
// Assumes a 16-bit byte address and 8-bit register data.
`ifndef BASE_CLOCK_DEFS_SVH
`define BASE_CLOCK_DEFS_SVH

`define SEL_A_ADDR 16'hFF56
`define SEL_B_ADDR 16'hFF39
`define DIV_A_ADDR 16'hFF57
`define DIV_B_ADDR 16'hFF3E
`define STATUS_ADDR 16'hFF60

`define SEL_RESET 4'h0
`define DIV_RESET 8'hFF
`define SEL_LSB 0
`define SEL_MSB 3
`define UPPER_ZERO 4'h0
`define READ_IDLE 8'h00

`define CODE_MAX_DIV 4'hA
`define CODE_TIMER 4'hB
`define PRESCALE_BITS 10
`define COUNT_ONE 8'h01
`define COUNT_ZERO 8'h00

`endif

// file: hw/base_clock_pkg.sv
// Types shared by the selector top and its per-channel divider.
// Assumes base_clock_defs.svh for the numbers.
package base_clock_pkg;

	typedef logic [3:0] code_t;

	typedef struct packed
	{
		logic [9:0] prescale_count;
		logic timer_prev;
		logic [1:0][3:0] sel;
		logic [1:0][7:0] div;
		logic [7:0] rdata;
	} top_state_s;

	typedef struct packed
	{
		logic [7:0] count;
		logic phase;
		logic base_pulse;
		logic baud_tick;
	} chan_state_s;

endpackage

// file: hw/chan_if.sv
// Carrier between the selector top and one channel divider.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface chan_if;
	base_clock_pkg::code_t code;
	logic [7:0] divisor;
	logic power;
	logic base_pulse;
	logic baud_tick;
	logic baud_phase;

	modport ctrl
	(
		output code,
		output divisor,
		output power,
		input base_pulse,
		input baud_tick,
		input baud_phase
	);

	modport chan
	(
		input code,
		input divisor,
		input power,
		output base_pulse,
		output baud_tick,
		output baud_phase
	);
endinterface

// file: hw/base_clock_channel.sv
// One channel: picks its base clock enable and runs the baud divider.
// Assumes prescale ticks and timer tick come from the top on clk.
`timescale 1ns/10ps
`include "base_clock_defs.svh"
module base_clock_channel
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [10:0] prescale_tick,
	input wire logic timer_tick,
	chan_if.chan ch
);

	base_clock_pkg::chan_state_s state;
	base_clock_pkg::chan_state_s next_state;
	logic base;
	logic div_pulse;

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_state = state;
		base = 1'b0;
		div_pulse = 1'b0;
		if (ch.code <= `CODE_MAX_DIV)
			base = prescale_tick[ch.code];
		else if (ch.code == `CODE_TIMER)
			base = timer_tick;
		next_state.base_pulse = base;
		next_state.baud_tick = 1'b0;
		if (!ch.power)
		begin
			next_state.count = `COUNT_ZERO;
			next_state.phase = 1'b0;
		end
		else if (base)
		begin
			if (state.count >= ch.divisor - `COUNT_ONE)
			begin
				div_pulse = 1'b1;
				next_state.count = `COUNT_ZERO;
				next_state.phase = !state.phase;
				next_state.baud_tick = state.phase;
			end
			else
				next_state.count = state.count + `COUNT_ONE;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign ch.base_pulse = state.base_pulse;
	assign ch.baud_tick = state.baud_tick;
	assign ch.baud_phase = state.phase;

	////////////////////////////////////////////////////////////////
	sequence s_div_by_four;
		(!ch.base_pulse || ch.code != 4'h2)[*3] ##1 (ch.base_pulse || ch.code != 4'h2);
	endsequence

	property p_div_by_four;
		@(posedge clk) disable iff (!reset_n)
		(ch.code == 4'h2 && ch.base_pulse && $stable(ch.code)) |=> s_div_by_four;
	endproperty
	a_div_by_four: assert property (p_div_by_four)
		else $error("code 2 base clock is not one pulse in four");

	property p_prohibited_silent;
		@(posedge clk) disable iff (!reset_n)
		(ch.code > `CODE_TIMER && $past(ch.code) > `CODE_TIMER) |-> !ch.base_pulse;
	endproperty
	a_prohibited_silent: assert property (p_prohibited_silent)
		else $error("prohibited code produced a base clock");

	property p_baud_halved;
		@(posedge clk) disable iff (!reset_n)
		div_pulse && ch.power |=> ch.baud_phase != $past(ch.baud_phase)
			&& ch.baud_tick == $past(ch.baud_phase);
	endproperty
	a_baud_halved: assert property (p_baud_halved)
		else $error("baud tick is not every second divider output");

	property p_single_pulse;
		@(posedge clk) disable iff (!reset_n)
		ch.base_pulse && ch.code != `SEL_RESET && $stable(ch.code) |=> !ch.base_pulse;
	endproperty
	a_single_pulse: assert property (p_single_pulse)
		else $error("divided base clock pulse lasted more than one cycle");

endmodule

// file: hw/uart_base_clock_select.sv
// Base-clock selector for two serial channels, with their baud dividers.
// Assumes a same-clock register master and same-clock timer output.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "base_clock_defs.svh"
module uart_base_clock_select
#(
	parameter int CHANNELS = 2
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] channel_power_on,
	input wire logic timer_fifty_output,
	output logic [1:0] serial_base_clock,
	output logic [1:0] baud_tick
);

	base_clock_pkg::top_state_s state;
	base_clock_pkg::top_state_s next_state;
	logic [10:0] prescale_tick;
	logic timer_tick;
	logic [7:0] status;
	logic [7:0] read_mux;

	chan_if ch[CHANNELS]();

	////////////////////////////////////////////////////////////////
	// Free-running prescaler: never cleared by register writes, so a
	// refresh of an unchanged code cannot shift the tick phase.
	assign prescale_tick[0] = 1'b1;

	genvar gi;
	generate
		for (gi = 1; gi <= `PRESCALE_BITS; gi++)
		begin : g_tick
			assign prescale_tick[gi] = &state.prescale_count[gi - 1:0];
		end
	endgenerate

	// Taken straight from the timer, independent of its pin function
	assign timer_tick = timer_fifty_output && !state.timer_prev;

	////////////////////////////////////////////////////////////////
	// Per-channel selector and divider
	generate
		for (gi = 0; gi < CHANNELS; gi++)
		begin : g_chan
			assign ch[gi].code = state.sel[gi];
			assign ch[gi].divisor = state.div[gi];
			assign ch[gi].power = channel_power_on[gi];
			assign serial_base_clock[gi] = ch[gi].base_pulse;
			assign baud_tick[gi] = ch[gi].baud_tick;

			base_clock_channel u_chan
			(
				.clk(clk),
				.reset_n(reset_n),
				.prescale_tick(prescale_tick),
				.timer_tick(timer_tick),
				.ch(ch[gi])
			);
		end
	endgenerate

	// Prohibited-code flags and divider phases, read-only
	assign status =
	{
		`UPPER_ZERO,
		ch[1].baud_phase,
		ch[0].baud_phase,
		state.sel[1] > `CODE_TIMER,
		state.sel[0] > `CODE_TIMER
	};

	////////////////////////////////////////////////////////////////
	// Register read decode
	always_comb
	begin
		read_mux = `READ_IDLE;
		if (reg_addr == `SEL_A_ADDR)
			read_mux = {`UPPER_ZERO, state.sel[0]};
		else if (reg_addr == `SEL_B_ADDR)
			read_mux = {`UPPER_ZERO, state.sel[1]};
		else if (reg_addr == `DIV_A_ADDR)
			read_mux = state.div[0];
		else if (reg_addr == `DIV_B_ADDR)
			read_mux = state.div[1];
		else if (reg_addr == `STATUS_ADDR)
			read_mux = status;
		else
			read_mux = `READ_IDLE;
	end

	////////////////////////////////////////////////////////////////
	// Next state. A write of a new code while powered is taken as
	// written; keeping the channel off then is software's duty.
	always_comb
	begin
		next_state = state;
		next_state.prescale_count = state.prescale_count + 10'h001;
		next_state.timer_prev = timer_fifty_output;
		next_state.rdata = reg_rd ? read_mux : `READ_IDLE;
		if (reg_wr)
		begin
			if (reg_addr == `SEL_A_ADDR)
				next_state.sel[0] = reg_wdata[`SEL_MSB:`SEL_LSB];
			else if (reg_addr == `SEL_B_ADDR)
				next_state.sel[1] = reg_wdata[`SEL_MSB:`SEL_LSB];
			else if (reg_addr == `DIV_A_ADDR)
				next_state.div[0] = reg_wdata;
			else if (reg_addr == `DIV_B_ADDR)
				next_state.div[1] = reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state.prescale_count <= '0;
			state.timer_prev <= 1'b0;
			state.sel[0] <= `SEL_RESET;
			state.sel[1] <= `SEL_RESET;
			state.div[0] <= `DIV_RESET;
			state.div[1] <= `DIV_RESET;
			state.rdata <= `READ_IDLE;
		end
		else
			state <= next_state;
	end

	assign reg_rdata = state.rdata;

	////////////////////////////////////////////////////////////////
	// Checks
	property p_reset_clear;
		@(posedge clk) disable iff (!reset_n)
		$rose(reset_n) |-> state.sel[0] == `SEL_RESET && state.sel[1] == `SEL_RESET;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("selection code not zero after reset");

	property p_upper_zero;
		@(posedge clk) disable iff (!reset_n)
		reg_rd && (reg_addr == `SEL_A_ADDR || reg_addr == `SEL_B_ADDR)
			|=> reg_rdata[7:4] == `UPPER_ZERO
			&& reg_rdata[3:0] == ($past(reg_addr) == `SEL_A_ADDR ? $past(state.sel[0])
			: $past(state.sel[1]));
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("selection read back wrong or upper bits set");

	sequence s_refresh_a;
		reg_wr && reg_addr == `SEL_A_ADDR && reg_wdata[3:0] == state.sel[0]
			&& channel_power_on[0];
	endsequence

	property p_refresh_quiet;
		@(posedge clk) disable iff (!reset_n)
		s_refresh_a |=> $stable(state.sel[0])
			&& state.prescale_count == $past(state.prescale_count) + 10'h001;
	endproperty
	a_refresh_quiet: assert property (p_refresh_quiet)
		else $error("refresh of same code disturbed the base clock");

	property p_timer_route;
		@(posedge clk) disable iff (!reset_n)
		$rose(timer_fifty_output) && state.sel[1] == `CODE_TIMER && $past(reset_n)
			|=> serial_base_clock[1];
	endproperty
	a_timer_route: assert property (p_timer_route)
		else $error("timer edge did not reach channel b base clock");

	property p_undivided;
		@(posedge clk) disable iff (!reset_n)
		state.sel[0] == `SEL_RESET && $past(state.sel[0]) == `SEL_RESET && $past(reset_n)
			|-> serial_base_clock[0];
	endproperty
	a_undivided: assert property (p_undivided)
		else $error("code 0 did not give the undivided clock");

	property p_independent;
		@(posedge clk) disable iff (!reset_n)
		reg_wr && reg_addr == `SEL_A_ADDR |=> $stable(state.sel[1]);
	endproperty
	a_independent: assert property (p_independent)
		else $error("channel a write changed channel b selection");

	property p_divider_idle;
		@(posedge clk) disable iff (!reset_n)
		!channel_power_on[0] ##1 !channel_power_on[0] |-> !baud_tick[0];
	endproperty
	a_divider_idle: assert property (p_divider_idle)
		else $error("baud tick while channel a is powered down");

	property p_slow_code;
		@(posedge clk) disable iff (!reset_n)
		state.sel[0] == `CODE_MAX_DIV && $stable(state.sel[0]) && serial_base_clock[0]
			|=> (!serial_base_clock[0] || state.sel[0] != `CODE_MAX_DIV) [*8];
	endproperty
	a_slow_code: assert property (p_slow_code)
		else $error("code 10 base clock pulsed too soon");

	////////////////////////////////////////////////////////////////
	// Register writes land in their own channel only
	sequence s_write_a;
		reg_wr && reg_addr == `SEL_A_ADDR;
	endsequence

	sequence s_write_b;
		reg_wr && reg_addr == `SEL_B_ADDR;
	endsequence

	property p_write_a_lands;
		@(posedge clk) disable iff (!reset_n)
		s_write_a |=> state.sel[0] == $past(reg_wdata[`SEL_MSB:`SEL_LSB]);
	endproperty
	a_write_a_lands: assert property (p_write_a_lands)
		else $error("channel a code not taken from the low nibble");

	property p_write_b_lands;
		@(posedge clk) disable iff (!reset_n)
		s_write_b |=> state.sel[1] == $past(reg_wdata[`SEL_MSB:`SEL_LSB]);
	endproperty
	a_write_b_lands: assert property (p_write_b_lands)
		else $error("channel b code not taken from the low nibble");

	property p_independent_b;
		@(posedge clk) disable iff (!reset_n)
		s_write_b |=> $stable(state.sel[0]);
	endproperty
	a_independent_b: assert property (p_independent_b)
		else $error("channel b write changed channel a selection");

	property p_rdata_idle;
		@(posedge clk) disable iff (!reset_n)
		!reg_rd |=> reg_rdata == `READ_IDLE;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data stood without a read strobe");

	property p_status_read;
		@(posedge clk) disable iff (!reset_n)
		reg_rd && reg_addr == `STATUS_ADDR
			|=> reg_rdata[7:4] == `UPPER_ZERO
			&& reg_rdata[1] == ($past(state.sel[1]) > `CODE_TIMER)
			&& reg_rdata[0] == ($past(state.sel[0]) > `CODE_TIMER);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("prohibited code flag read back wrong");

	////////////////////////////////////////////////////////////////
	// Free prescaler, so a code refresh never slips the tick phase
	property p_prescale_free;
		@(posedge clk) disable iff (!reset_n)
		$past(reset_n) |-> state.prescale_count == $past(state.prescale_count) + 10'h001;
	endproperty
	a_prescale_free: assert property (p_prescale_free)
		else $error("prescaler skipped or restarted");

	property p_timer_route_a;
		@(posedge clk) disable iff (!reset_n)
		$rose(timer_fifty_output) && state.sel[0] == `CODE_TIMER && $past(reset_n)
			|=> serial_base_clock[0];
	endproperty
	a_timer_route_a: assert property (p_timer_route_a)
		else $error("timer edge did not reach channel a base clock");

	// Timer code: base clock only ever follows a timer rising edge
	property p_timer_only_a;
		@(posedge clk) disable iff (!reset_n)
		state.sel[0] == `CODE_TIMER && $past(state.sel[0]) == `CODE_TIMER && !$past(timer_tick)
			|-> !serial_base_clock[0];
	endproperty
	a_timer_only_a: assert property (p_timer_only_a)
		else $error("channel a base clock without a timer edge");

	property p_timer_only_b;
		@(posedge clk) disable iff (!reset_n)
		state.sel[1] == `CODE_TIMER && $past(state.sel[1]) == `CODE_TIMER && !$past(timer_tick)
			|-> !serial_base_clock[1];
	endproperty
	a_timer_only_b: assert property (p_timer_only_b)
		else $error("channel b base clock without a timer edge");

	property p_undivided_b;
		@(posedge clk) disable iff (!reset_n)
		state.sel[1] == `SEL_RESET && $past(state.sel[1]) == `SEL_RESET && $past(reset_n)
			|-> serial_base_clock[1];
	endproperty
	a_undivided_b: assert property (p_undivided_b)
		else $error("code 0 did not give channel b the undivided clock");

	property p_divider_idle_b;
		@(posedge clk) disable iff (!reset_n)
		!channel_power_on[1] ##1 !channel_power_on[1] |-> !baud_tick[1];
	endproperty
	a_divider_idle_b: assert property (p_divider_idle_b)
		else $error("baud tick while channel b is powered down");

endmodule

// file: dv/timer_model.sv
// Partner timer: square wave of fixed half period, fifty percent duty.
// Assumes the selector's clk; output low while stopped.
`timescale 1ns/10ps
module timer_model
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic [7:0] half,
	output logic wave
);
	logic [7:0] count;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count <= 8'h00;
			wave <= 1'b0;
		end
		else if (!run)
		begin
			count <= 8'h00;
			wave <= 1'b0;
		end
		else if (count == half - 8'h01)
		begin
			count <= 8'h00;
			wave <= ~wave;
		end
		else
			count <= count + 8'h01;
	end
endmodule

// file: dv/uart_base_clock_select_test.sv
// Self-checking bench for the serial base-clock selector.
// Assumes timer_model as the timer partner on the same clock.
`timescale 1ns/10ps
`include "base_clock_defs.svh"
module uart_base_clock_select_test;
	logic clk;
	logic reset_n;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [1:0] channel_power_on;
	logic timer_fifty_output;
	logic [1:0] serial_base_clock;
	logic [1:0] baud_tick;
	logic timer_run;
	int mismatches;
	int num_checks;
	int sb;
	int bt;

	uart_base_clock_select u_dut
	(
		.clk(clk),
		.reset_n(reset_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.channel_power_on(channel_power_on),
		.timer_fifty_output(timer_fifty_output),
		.serial_base_clock(serial_base_clock),
		.baud_tick(baud_tick)
	);

	timer_model u_timer
	(
		.clk(clk),
		.reset_n(reset_n),
		.run(timer_run),
		.half(8'h04),
		.wave(timer_fifty_output)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		num_checks++;
		if (got != exp)
		begin
			mismatches++;
			$display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	// Window of n cycles; a write strobe fires in cycle w if w is in range
	task automatic count(input int ch, input int n, input int w);
		sb = 0;
		bt = 0;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			reg_wr <= (i == w);
			// Sampled mid-cycle, clear of the edge that launches it
			@(negedge clk);
			if (serial_base_clock[ch] === 1'b1)
				sb++;
			if (baud_tick[ch] === 1'b1)
				bt++;
		end
	endtask

	////////////////////////////////////////////////////////////////
	task automatic test_reset(input int hold);
		logic [7:0] d;
		if (hold > 0)
		begin
			@(posedge clk);
			reset_n <= 1'b0;
			repeat (hold) @(posedge clk);
			reset_n <= 1'b1;
			@(posedge clk);
		end
		rd(`SEL_A_ADDR, d);
		chk_reg(d, 8'h00);
		rd(`SEL_B_ADDR, d);
		chk_reg(d, 8'h00);
		rd(`DIV_A_ADDR, d);
		chk_reg(d, `DIV_RESET);
		count(0, 64, -1);
		chk_cnt(sb, 64);
		$display("test reset done");
	endtask

	task automatic test_fields;
		logic [7:0] d;
		wr(`SEL_A_ADDR, 8'hF5);
		wr(`SEL_B_ADDR, 8'h0C);
		count(1, 64, -1);
		chk_cnt(sb, 0);
		rd(`STATUS_ADDR, d);
		chk_reg(d, 8'h02);
		wr(`SEL_B_ADDR, 8'h03);
		rd(`SEL_A_ADDR, d);
		chk_reg(d, 8'h05);
		rd(`SEL_B_ADDR, d);
		chk_reg(d, 8'h03);
		rd(16'hFF00, d);
		chk_reg(d, 8'h00);
		count(1, 2048, -1);
		chk_cnt(sb, 256);
		count(0, 2048, -1);
		chk_cnt(sb, 64);
		$display("test fields done");
	endtask

	task automatic test_divide;
		for (int k = 0; k <= 10; k++)
		begin
			wr(`SEL_A_ADDR, 8'(k));
			count(0, 2048, -1);
			chk_cnt(sb, 2048 >> k);
		end
		$display("test divide done");
	endtask

	task automatic test_timer;
		timer_run <= 1'b1;
		wr(`SEL_A_ADDR, {4'h0, `CODE_TIMER});
		wr(`SEL_B_ADDR, {4'h0, `CODE_TIMER});
		count(0, 16, -1);
		count(0, 2048, -1);
		chk_cnt(sb, 256);
		count(1, 2048, -1);
		chk_cnt(sb, 256);
		timer_run <= 1'b0;
		$display("test timer done");
	endtask

	// Code and divisor set while powered down; same code rewritten in traffic
	task automatic test_refresh;
		wr(`SEL_A_ADDR, 8'h01);
		wr(`DIV_A_ADDR, 8'h04);
		wr(`SEL_B_ADDR, 8'h01);
		wr(`DIV_B_ADDR, 8'h04);
		channel_power_on <= 2'b11;
		count(0, 32, -1);
		@(posedge clk);
		reg_addr <= `SEL_A_ADDR;
		reg_wdata <= 8'h01;
		count(0, 2048, 100);
		chk_cnt(sb, 1024);
		chk_cnt(bt, 128);
		count(1, 2048, -1);
		chk_cnt(sb, 1024);
		chk_cnt(bt, 128);
		$display("test refresh done");
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		reset_n = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		channel_power_on = 2'b00;
		timer_run = 1'b0;
		mismatches = 0;
		num_checks = 0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		test_reset(0);
		test_fields;
		test_divide;
		test_timer;
		test_refresh;
		test_reset(4);
		stop_test;
	end

	// Hang guard
	initial
	begin
		#2500000;
		mismatches++;
		stop_test;
	end
endmodule
